// >>> verilog/atto_pkg.sv
// shared constants for the acceleration, temperature and time stamp outputs
package atto_pkg;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 7;
   localparam logic [6:0] OFS_ACC_X_FRAC = 7'h10;
   localparam logic [6:0] OFS_ACC_X_WORD = 7'h12;
   localparam logic [6:0] OFS_ACC_Y_FRAC = 7'h14;
   localparam logic [6:0] OFS_ACC_Y_WORD = 7'h16;
   localparam logic [6:0] OFS_ACC_Z_FRAC = 7'h18;
   localparam logic [6:0] OFS_ACC_Z_WORD = 7'h1A;
   localparam logic [6:0] OFS_THERMAL = 7'h1C;
   localparam logic [6:0] OFS_SYNC_TIME = 7'h1E;
   localparam logic [2:0] SYNC_MODE_SCALED = 3'h2;
   localparam int unsigned SYNC_MODE_LSB = 2;
   localparam int unsigned SYNC_MODE_MSB = 4;
   // one stamp tick is 490 clocks of 100 ns, 49.0 us (49020 ns truncated to whole clocks)
   localparam int unsigned STAMP_TICK_NS = 49020;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned STAMP_TICK_CYC = STAMP_TICK_NS / CLK_PERIOD_NS;
   localparam logic [9:0] STAMP_DIV_LAST = 10'(STAMP_TICK_CYC - 1);
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   localparam int unsigned NUM_WORDS = 8;
endpackage

// >>> verilog/atto_regmem.sv
// eight-word output register store with registered read data
`timescale 1ns/100ps
`default_nettype none
module atto_regmem
   import atto_pkg::*;
(
   input wire logic clk,
   input wire logic load,
   input wire logic [NUM_WORDS*DATA_W-1:0] load_data,
   input wire logic [2:0] rd_index,
   output logic [DATA_W-1:0] rd_data
);
   logic [DATA_W-1:0] mem [NUM_WORDS];
   // no reset: contents undefined until first update
   always_ff @(posedge clk) begin
      if (load) begin
         for (int i = 0; i < NUM_WORDS; i++) begin
            mem[i] <= load_data[i*DATA_W +: DATA_W];
         end
      end
      rd_data <= mem[rd_index];
   end
endmodule
`default_nettype wire

// >>> verilog/atto_outputs.sv
// output register group: acceleration, temperature and sync time stamp
`timescale 1ns/100ps
`default_nettype none
module atto_outputs
   import atto_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic SYNC,
   input wire logic [2:0] SYNC_MODE,
   input wire logic SAMPLE_STROBE,
   input wire logic UPDATE_STROBE,
   input wire logic signed [31:0] ACC_X,
   input wire logic signed [31:0] ACC_Y,
   input wire logic signed [31:0] ACC_Z,
   input wire logic signed [15:0] THERMAL,
   input wire logic RD_EN,
   input wire logic WR_EN,
   input wire logic [6:0] ADDR,
   input wire logic [15:0] WR_DATA,
   output logic [15:0] RD_DATA,
   output logic RD_VALID,
   output logic STAMP_VALID
);
   typedef struct packed {
      logic sync_meta_reg;
      logic sync_sync_reg;
      logic sync_prev_reg;
      logic [9:0] div_reg;
      logic [15:0] run_reg;
      logic [15:0] last_sample_reg;
      logic rd_pend_reg;
      logic rd_hit_reg;
      logic rd_valid_reg;
      logic stamp_valid_reg;
      logic [15:0] rd_data_reg;
   } atto_state_type;

   atto_state_type s_reg;
   atto_state_type s_next;
   logic [15:0] mem_rd;
   logic [NUM_WORDS*DATA_W-1:0] load_word;

   function automatic logic addr_mapped(input logic [6:0] a);
      addr_mapped = (a >= OFS_ACC_X_FRAC) && (a <= OFS_SYNC_TIME)
         && (a[0] == 1'b0);
   endfunction

   function automatic logic [2:0] addr_index(input logic [6:0] a);
      logic [6:0] d;
      d = a - OFS_ACC_X_FRAC;
      addr_index = d[3:1];
   endfunction

   // word order follows offsets: frac below word for each axis
   always_comb begin
      load_word = {s_reg.last_sample_reg, THERMAL,
         ACC_Z[31:16], ACC_Z[15:0],
         ACC_Y[31:16], ACC_Y[15:0],
         ACC_X[31:16], ACC_X[15:0]};
   end

   atto_regmem u_mem (
      .clk(CLK),
      .load(UPDATE_STROBE),
      .load_data(load_word),
      .rd_index(addr_index(ADDR)),
      .rd_data(mem_rd)
   );

   always_comb begin
      logic edge_seen;
      logic tick;
      s_next = s_reg;
      edge_seen = s_reg.sync_sync_reg && !s_reg.sync_prev_reg;
      tick = (s_reg.div_reg == STAMP_DIV_LAST);
      s_next.sync_meta_reg = SYNC;
      s_next.sync_sync_reg = s_reg.sync_meta_reg;
      s_next.sync_prev_reg = s_reg.sync_sync_reg;
      if (edge_seen) begin
         s_next.div_reg = 10'h000;
         s_next.run_reg = ZERO_WORD;
      end else if (tick) begin
         s_next.div_reg = 10'h000;
         s_next.run_reg = s_reg.run_reg + 16'h0001;
      end else begin
         s_next.div_reg = s_reg.div_reg + 10'h001;
      end
      if (SAMPLE_STROBE) begin
         s_next.last_sample_reg = s_reg.run_reg;
      end
      s_next.stamp_valid_reg = (SYNC_MODE == SYNC_MODE_SCALED);
      // writes never touch the store
      s_next.rd_pend_reg = RD_EN;
      s_next.rd_hit_reg = RD_EN && addr_mapped(ADDR);
      s_next.rd_valid_reg = s_reg.rd_pend_reg;
      if (s_reg.rd_pend_reg) begin
         s_next.rd_data_reg = s_reg.rd_hit_reg ? mem_rd : ZERO_WORD;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign RD_DATA = s_reg.rd_data_reg;
   assign RD_VALID = s_reg.rd_valid_reg;
   assign STAMP_VALID = s_reg.stamp_valid_reg;

   sequence seq_read_req;
      RD_EN;
   endsequence
   sequence seq_read_done;
      ##2 RD_VALID;
   endsequence

   a_read_answer: assert property (@(posedge CLK) disable iff (RST)
      seq_read_req |-> seq_read_done)
      else $error("read not answered in two cycles");
   a_stamp_mode_valid: assert property (@(posedge CLK) disable iff (RST)
      (SYNC_MODE == SYNC_MODE_SCALED) |=> STAMP_VALID)
      else $error("stamp valid missing in scaled mode");
   a_stamp_mode_off: assert property (@(posedge CLK) disable iff (RST)
      (SYNC_MODE != SYNC_MODE_SCALED) |=> !STAMP_VALID)
      else $error("stamp valid outside scaled mode");
   a_stamp_edge_clear: assert property (@(posedge CLK) disable iff (RST)
      (s_reg.sync_sync_reg && !s_reg.sync_prev_reg) |=>
      (s_reg.run_reg == ZERO_WORD && s_reg.div_reg == 10'h000))
      else $error("stamp not cleared on sync edge");
   a_stamp_tick_step: assert property (@(posedge CLK) disable iff (RST)
      (!(s_reg.sync_sync_reg && !s_reg.sync_prev_reg)
      && s_reg.div_reg == STAMP_DIV_LAST) |=>
      s_reg.run_reg == $past(s_reg.run_reg) + 16'h0001)
      else $error("stamp tick did not advance");
   a_sample_capture: assert property (@(posedge CLK) disable iff (RST)
      SAMPLE_STROBE |=> s_reg.last_sample_reg == $past(s_reg.run_reg))
      else $error("final sample time not captured");
   a_unmapped_zero: assert property (@(posedge CLK) disable iff (RST)
      (RD_EN && !addr_mapped(ADDR)) |-> ##2 RD_DATA == ZERO_WORD)
      else $error("unmapped read not zero");
   a_axis_word_pair: assert property (@(posedge CLK) disable iff (RST)
      (UPDATE_STROBE ##1 (RD_EN && ADDR == OFS_ACC_X_WORD
      && !UPDATE_STROBE)) |-> ##2 RD_DATA == $past(ACC_X[31:16], 3))
      else $error("high word mismatch");
   a_axis_frac_pair: assert property (@(posedge CLK) disable iff (RST)
      (UPDATE_STROBE ##1 (RD_EN && ADDR == OFS_ACC_X_FRAC
      && !UPDATE_STROBE)) |-> ##2 RD_DATA == $past(ACC_X[15:0], 3))
      else $error("low word mismatch");
   a_thermal_word: assert property (@(posedge CLK) disable iff (RST)
      (UPDATE_STROBE ##1 (RD_EN && ADDR == OFS_THERMAL
      && !UPDATE_STROBE)) |-> ##2 RD_DATA == $past(THERMAL, 3))
      else $error("temperature mismatch");
   a_y_high_word: assert property (@(posedge CLK) disable iff (RST)
      (UPDATE_STROBE ##1 (RD_EN && ADDR == OFS_ACC_Y_WORD
      && !UPDATE_STROBE)) |-> ##2 RD_DATA == $past(ACC_Y[31:16], 3))
      else $error("y high word mismatch");
endmodule
`default_nettype wire

// >>> bench/atto_host.sv
// host model that issues register reads
`timescale 1ns/100ps
`default_nettype none
module atto_host (
   input wire logic clk,
   input wire logic rd_valid,
   input wire logic [15:0] rd_data,
   output logic rd_en,
   output logic [6:0] addr
);
   initial begin
      rd_en = 1'b0;
      addr = 7'h00;
   end
   // one read; each half of an axis is fetched this way
   task automatic rd(input logic [6:0] a, output logic [15:0] d,
      output bit ok);
      @(negedge clk);
      rd_en = 1'b1;
      addr = a;
      @(negedge clk);
      rd_en = 1'b0;
      addr = ~a; // a released address does not hold
      ok = 1'b0;
      d = 16'h0000;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (rd_valid === 1'b1) begin
            d = rd_data;
            ok = 1'b1;
         end else
            @(negedge clk);
      end
   endtask
endmodule
`default_nettype wire

// >>> bench/test_atto_outputs.sv
// self-checking bench for the output register group
`timescale 1ns/100ps
`default_nettype none
module test_atto_outputs;
   import atto_pkg::*;
   logic clk, rst, sync, smp, upd, wr_en, rd_en, rdv, stv;
   logic [2:0] mode;
   logic signed [31:0] ax, ay, az;
   logic signed [15:0] th;
   logic [6:0] addr;
   logic [15:0] wd, rdd;
   int n_fail, tests_run;
   atto_outputs i_dut (.CLK(clk), .RST(rst), .SYNC(sync),
      .SYNC_MODE(mode), .SAMPLE_STROBE(smp), .UPDATE_STROBE(upd),
      .ACC_X(ax), .ACC_Y(ay), .ACC_Z(az), .THERMAL(th),
      .RD_EN(rd_en), .WR_EN(wr_en), .ADDR(addr), .WR_DATA(wd),
      .RD_DATA(rdd), .RD_VALID(rdv), .STAMP_VALID(stv));
   atto_host i_host (.clk(clk), .rd_valid(rdv), .rd_data(rdd),
      .rd_en(rd_en), .addr(addr));
   task automatic wrap_up();
      $display("checks %0d fails %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [15:0] e, g);
      tests_run++;
      if (e !== g) begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rd(input string n, input logic [6:0] a,
      input logic [15:0] e);
      logic [15:0] d;
      bit ok;
      i_host.rd(a, d, ok);
      if (!ok) begin
         n_fail++;
         $display("MISMATCH %s exp answer got none", n);
         wrap_up();
      end
      cmp(n, e, d);
   endtask
   // sample then publish
   task automatic strobe();
      @(negedge clk);
      smp = 1'b1;
      @(negedge clk);
      smp = 1'b0;
      upd = 1'b1;
      @(negedge clk);
      upd = 1'b0;
   endtask
   // update pulse with a read taken on the very next edge
   task automatic upd_rd(input string n, input logic [6:0] a,
      input logic [15:0] e);
      @(negedge clk);
      upd = 1'b1;
      fork
         rd(n, a, e);
         begin
            @(negedge clk);
            upd = 1'b0;
         end
      join
   endtask
   task automatic t_axes();
      ax = 32'h8300_0001;
      ay = 32'h7D00_FFFF;
      az = 32'hFFFF_FFFE;
      th = 16'hFE70;
      strobe();
      rd("x frac", OFS_ACC_X_FRAC, 16'h0001);
      rd("x word", OFS_ACC_X_WORD, 16'h8300);
      rd("y frac", OFS_ACC_Y_FRAC, 16'hFFFF);
      rd("y word", OFS_ACC_Y_WORD, 16'h7D00);
      rd("z frac", OFS_ACC_Z_FRAC, 16'hFFFE);
      rd("z word", OFS_ACC_Z_WORD, 16'hFFFF);
      rd("thermal", OFS_THERMAL, 16'hFE70);
      upd_rd("x frac up", OFS_ACC_X_FRAC, 16'h0001);
      upd_rd("x word up", OFS_ACC_X_WORD, 16'h8300);
      upd_rd("y word up", OFS_ACC_Y_WORD, 16'h7D00);
      upd_rd("thermal up", OFS_THERMAL, 16'hFE70);
      $display("test axes done");
   endtask
   task automatic t_write();
      wr_en = 1'b1;
      wd = 16'h5A5A;
      rd("x frac wr", OFS_ACC_X_FRAC, 16'h0001);
      wr_en = 1'b0;
      rd("unmapped", 7'h20, 16'h0000);
      $display("test write done");
   endtask
   task automatic t_stamp();
      mode = SYNC_MODE_SCALED;
      repeat (2) @(negedge clk);
      cmp("stamp ok", 16'h0001, {15'h0000, stv});
      sync = 1'b1;
      repeat (4) @(negedge clk);
      sync = 1'b0;
      repeat (1100) @(negedge clk);
      strobe();
      rd("stamp", OFS_SYNC_TIME, 16'h0002);
      mode = 3'h0;
      repeat (2) @(negedge clk);
      cmp("stamp off", 16'h0000, {15'h0000, stv});
      $display("test stamp done");
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      {n_fail, tests_run} = '0;
      rst = 1'b1;
      {sync, smp, upd, wr_en, mode, wd, ax, ay, az, th} = '0;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      t_axes();
      t_write();
      t_stamp();
      wrap_up();
   end
endmodule
`default_nettype wire
